// >>> rtl/redist_misc_pkg.sv
// Constants for the redistributor SGI/PPI miscellaneous register frame
package redist_misc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  localparam logic [15:0] OFS_NONSECURE_ACCESS_CONTROL = 16'h0E00;
  localparam logic [15:0] OFS_MISC_STATUS              = 16'hC000;
  localparam logic [15:0] OFS_INTERRUPT_ERROR_VALID    = 16'hC008;
  localparam logic [15:0] OFS_SGI_DEFAULT_LO           = 16'hC010;
  localparam logic [15:0] OFS_SGI_DEFAULT_HI           = 16'hC014;
  localparam logic [15:0] OFS_CONFIG_ID_LOW            = 16'hF000;
  localparam logic [15:0] OFS_CONFIG_ID_HIGH           = 16'hF004;
  localparam logic [15:0] OFS_IRQ_STATUS               = 16'hC020;
  localparam logic [15:0] OFS_IRQ_MASK                 = 16'hC024;

  localparam int unsigned BIT_CORE_ACTIVE   = 31;
  localparam int unsigned BIT_WAKE_REQUEST  = 30;
  localparam int unsigned BIT_ACCESS_SEC    = 4;
  localparam int unsigned BIT_G1_SECURE     = 2;
  localparam int unsigned BIT_G1_NONSECURE  = 1;
  localparam int unsigned BIT_G0            = 0;

  localparam logic [31:0] RST_NONSECURE_ACCESS_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_INTERRUPT_ERROR_VALID    = 32'h0000_0000;
  localparam logic [63:0] RST_SGI_DEFAULT    = 64'h0000_0000_0000_0000;
  // Reserved bit 4n+3 of each SGI nibble
  localparam logic [63:0] SGI_DEFAULT_MASK   = 64'h7777_7777_7777_7777;
  localparam logic [1:0]  RST_IRQ            = 2'h0;
  // Interrupt status bits
  localparam int unsigned IRQ_ERROR       = 0;
  localparam int unsigned IRQ_WAKE        = 1;
  // Arbitrary neutral configuration identification values
  localparam logic [31:0] CONFIG_ID_LOW_VAL  = 32'h0000_0000;
  localparam logic [31:0] CONFIG_ID_HIGH_VAL = 32'h0000_0000;
endpackage : redist_misc_pkg

// >>> rtl/redist_sgi_ppi_misc_status.sv
// Redistributor SGI/PPI miscellaneous status and error register frame
//
// Overview of operation
// R1: Status bit 31 reads the live core-active input level.
// R2: Bit 31 is meaningless while core sleeping or children quiesced.
// R3: Status bit 30 reads the live wake request level.
// R4: Status bit 4 reads 0 for secure access, 1 for non-secure.
// R5: Two security states: bit 2 is G1 secure enable, secure reads only.
// R6: Single security state: bit 2 always reads zero.
// R7: Bit 1 gives G1 non-secure enable, gated by routing on two-state non-secure reads.
// R8: Bit 0 gives G0 enable to secure reads or single-state reads.
// R9: Two states, non-secure read: bit 0 is G1 NS enable when routing 0.
// R10: Writing 1 to an error-valid bit clears it; writing 0 does nothing.
// R11: Reserved status bits and reserved offsets read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module redist_sgi_ppi_misc_status
  import redist_misc_pkg::*;
(
  input  wire logic                         CLK,              // Clock
  input  wire logic                         RSTN,             // Sync reset
  input  wire logic [redist_misc_pkg::ADDR_W-1:0] ADDR,       // Byte address
  input  wire logic [redist_misc_pkg::DATA_W-1:0] WDATA,      // Write data
  input  wire logic                         WR,               // Write strobe
  input  wire logic                         RD,               // Read strobe
  input  wire logic                         ACCESS_NONSECURE, // 1 = NS access
  output logic [redist_misc_pkg::DATA_W-1:0] RDATA,           // Read data
  input  wire logic                         CORE_ACTIVE,      // Core active
  input  wire logic                         WAKE_REQUEST,     // Wake request
  input  wire logic                         CORE_SLEEP_FLAG,  // Core asleep
  input  wire logic                         CHILDREN_QUIESCED_FLAG, // Quiesced
  input  wire logic                         SECURITY_DISABLE_FLAG,  // One state
  input  wire logic                         NONSECURE_AFFINITY_ROUTING, // Route
  input  wire logic                         G0_IF_ENABLE,     // Group 0 enable
  input  wire logic                         G1_SECURE_IF_ENABLE,    // G1 S
  input  wire logic                         G1_NONSECURE_IF_ENABLE, // G1 NS
  input  wire logic [31:0]                  ERROR_SET,        // Error events
  output logic [31:0]                       NONSECURE_ACCESS_CONTROL, // NSAC
  output logic [31:0]                       INTERRUPT_ERROR_VALID,    // Errors
  output logic [63:0]                       SGI_DEFAULT_SETTINGS, // Defaults
  output logic                              STATUS_UNDEFINED, // Bit 31 unsafe
  output logic                              IRQ               // Interrupt
);
  import redist_misc_pkg::*;

  typedef struct packed {
    logic [31:0] nsac;
    logic [31:0] errv;
    logic [63:0] sgid;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        wake_prev;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Status word, composed per access since bits depend on requester security
  function automatic logic [31:0] misc_word(input logic ns);
    logic [31:0] w;
    w = 32'h0000_0000;                                       // [R11]
    w[BIT_CORE_ACTIVE]  = CORE_ACTIVE;                       // [R1]
    w[BIT_WAKE_REQUEST] = WAKE_REQUEST;                      // [R3]
    w[BIT_ACCESS_SEC]   = ns;                                // [R4]
    if (SECURITY_DISABLE_FLAG) begin
      w[BIT_G1_SECURE]    = 1'b0;                            // [R6]
      w[BIT_G1_NONSECURE] = G1_NONSECURE_IF_ENABLE;          // [R7]
      w[BIT_G0]           = G0_IF_ENABLE;                    // [R8]
    end else if (!ns) begin
      w[BIT_G1_SECURE]    = G1_SECURE_IF_ENABLE;             // [R5]
      w[BIT_G1_NONSECURE] = G1_NONSECURE_IF_ENABLE;          // [R7]
      w[BIT_G0]           = G0_IF_ENABLE;                    // [R8]
    end else begin
      w[BIT_G1_SECURE]    = 1'b0;                            // [R5]
      w[BIT_G1_NONSECURE] = NONSECURE_AFFINITY_ROUTING
                            & G1_NONSECURE_IF_ENABLE;        // [R7]
      w[BIT_G0]           = ~NONSECURE_AFFINITY_ROUTING
                            & G1_NONSECURE_IF_ENABLE;        // [R9]
    end
    return w;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.wake_prev = WAKE_REQUEST;
    if (RD) begin
      case (ADDR)
        OFS_NONSECURE_ACCESS_CONTROL: s_d.rdata = s_q.nsac;
        OFS_MISC_STATUS:              s_d.rdata = misc_word(ACCESS_NONSECURE);
        OFS_INTERRUPT_ERROR_VALID:    s_d.rdata = s_q.errv;
        OFS_SGI_DEFAULT_LO:           s_d.rdata = s_q.sgid[31:0];
        OFS_SGI_DEFAULT_HI:           s_d.rdata = s_q.sgid[63:32];
        OFS_CONFIG_ID_LOW:            s_d.rdata = CONFIG_ID_LOW_VAL;
        OFS_CONFIG_ID_HIGH:           s_d.rdata = CONFIG_ID_HIGH_VAL;
        OFS_IRQ_STATUS:               s_d.rdata = {30'h0, s_q.irq_stat};
        OFS_IRQ_MASK:                 s_d.rdata = {30'h0, s_q.irq_mask};
        default:                      s_d.rdata = 32'h0000_0000; // [R11]
      endcase
    end else begin
      s_d.rdata = 32'h0000_0000;
    end
    if (WR) begin
      case (ADDR)
        OFS_NONSECURE_ACCESS_CONTROL: s_d.nsac = WDATA;
        OFS_INTERRUPT_ERROR_VALID:    s_d.errv = s_q.errv & ~WDATA; // [R10]
        OFS_SGI_DEFAULT_LO:
          s_d.sgid[31:0]  = WDATA & SGI_DEFAULT_MASK[31:0];
        OFS_SGI_DEFAULT_HI:
          s_d.sgid[63:32] = WDATA & SGI_DEFAULT_MASK[63:32];
        OFS_IRQ_STATUS:               s_d.irq_stat = s_q.irq_stat & ~WDATA[1:0];
        OFS_IRQ_MASK:                 s_d.irq_mask = WDATA[1:0];
        default: ;                                            // [R11]
      endcase
    end
    // Set wins over a same-cycle write-one clear
    s_d.errv = s_d.errv | ERROR_SET;                          // [R10]
    if (|ERROR_SET) begin
      s_d.irq_stat[IRQ_ERROR] = 1'b1;
    end
    if (WAKE_REQUEST && !s_q.wake_prev) begin
      s_d.irq_stat[IRQ_WAKE] = 1'b1;
    end
    if (!RSTN) begin
      s_d.nsac      = RST_NONSECURE_ACCESS_CONTROL;
      s_d.errv      = RST_INTERRUPT_ERROR_VALID;
      s_d.sgid      = RST_SGI_DEFAULT;
      s_d.irq_stat  = RST_IRQ;
      s_d.irq_mask  = RST_IRQ;
      s_d.wake_prev = 1'b0;
      s_d.rdata     = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK) begin
    s_q <= s_d;
  end

  assign RDATA                    = s_q.rdata;
  assign NONSECURE_ACCESS_CONTROL = s_q.nsac;
  assign INTERRUPT_ERROR_VALID    = s_q.errv;
  assign SGI_DEFAULT_SETTINGS     = s_q.sgid;
  // Flags bit 31 as not trustworthy while the core sleeps or its children are quiesced
  assign STATUS_UNDEFINED = CORE_SLEEP_FLAG | CHILDREN_QUIESCED_FLAG; // [R2]
  assign IRQ = |(s_q.irq_stat & s_q.irq_mask);
endmodule // redist_sgi_ppi_misc_status
`default_nettype wire

// >>> testbench/core_model.sv
// Core-side model: enables, power flags and activity levels
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic       clk,   // Clock
  input  wire logic [6:0] cfg,   // Wanted levels
  output logic [6:0]      lines  // Sleep, quiesce, G0, G1S, G1NS, act, wake
);
  // Levels move just after an edge, as a real core's would
  always_ff @(posedge clk) lines <= cfg;
endmodule // core_model
`default_nettype wire

// >>> testbench/redist_misc_checker.sv
// Checker for the status word and read port
`timescale 1ns/10ps
`default_nettype none
module redist_misc_checker (
  input wire logic        CLK,                        // Clock
  input wire logic        RSTN,                       // Sync reset
  input wire logic        RD,                         // Read strobe
  input wire logic        ACCESS_NONSECURE,           // NS access
  input wire logic        CORE_ACTIVE,                // Core active
  input wire logic        IRQ,                        // Interrupt
  input wire logic        WAKE_REQUEST,               // Wake request
  input wire logic        SECURITY_DISABLE_FLAG,      // One state
  input wire logic        G0_IF_ENABLE,               // G0 enable
  input wire logic        NONSECURE_AFFINITY_ROUTING, // Routing
  input wire logic        G1_SECURE_IF_ENABLE,        // G1 S enable
  input wire logic        G1_NONSECURE_IF_ENABLE,     // G1 NS enable
  input wire logic        CORE_SLEEP_FLAG,            // Core asleep
  input wire logic        CHILDREN_QUIESCED_FLAG,     // Quiesced
  input wire logic        STATUS_UNDEFINED,           // Bit 31 unsafe
  input wire logic [15:0] ADDR,                       // Byte address
  input wire logic [31:0] RDATA                       // Read data
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic st;
  logic [2:0] e;
  logic full;
  assign st = RD && ADDR == 16'hC000;
  assign full = SECURITY_DISABLE_FLAG || !ACCESS_NONSECURE;
  assign e[2] = !SECURITY_DISABLE_FLAG && !ACCESS_NONSECURE
                && G1_SECURE_IF_ENABLE;
  assign e[1] = G1_NONSECURE_IF_ENABLE && (full || NONSECURE_AFFINITY_ROUTING);
  assign e[0] = full ? G0_IF_ENABLE
                : G1_NONSECURE_IF_ENABLE && !NONSECURE_AFFINITY_ROUTING;
  a_core_active: assert property (
    st |=> RDATA[31] == $past(CORE_ACTIVE))
    else $error("bit 31 wrong");
  a_wake_level: assert property (
    st |=> RDATA[30] == $past(WAKE_REQUEST))
    else $error("bit 30 wrong");
  a_access_type: assert property (
    st |=> RDATA[4] == $past(ACCESS_NONSECURE))
    else $error("bit 4 wrong");
  a_g1s_bit: assert property (
    st |=> RDATA[2] == $past(e[2]))
    else $error("bit 2 wrong");
  a_g1ns_bit: assert property (
    st |=> RDATA[1] == $past(e[1]))
    else $error("bit 1 wrong");
  a_g0_bit: assert property (
    st |=> RDATA[0] == $past(e[0]))
    else $error("bit 0 wrong");
  a_reserved_zero: assert property (
    st |=> {RDATA[29:5], RDATA[3]} == '0)
    else $error("reserved status bits set");
  a_unmapped_zero: assert property (
    RD && ADDR == 16'hC004 |=> RDATA == '0)
    else $error("reserved offset not zero");
  a_undef_flag: assert property (STATUS_UNDEFINED ==
    (CORE_SLEEP_FLAG || CHILDREN_QUIESCED_FLAG)) else $error("undef flag wrong");
  c_ns_read: cover property (st && ACCESS_NONSECURE);
  c_one_state: cover property (st && SECURITY_DISABLE_FLAG);
  c_irq: cover property (IRQ);
endmodule // redist_misc_checker
`default_nettype wire

// >>> testbench/test_redist_sgi_ppi_misc_status.sv
// Bench for the miscellaneous status register frame
`timescale 1ns/10ps
`default_nettype none
bind redist_sgi_ppi_misc_status redist_misc_checker CHK (
  .CLK(CLK), .RSTN(RSTN), .RD(RD), .ACCESS_NONSECURE(ACCESS_NONSECURE),
  .CORE_ACTIVE(CORE_ACTIVE), .IRQ(IRQ), .WAKE_REQUEST(WAKE_REQUEST),
  .SECURITY_DISABLE_FLAG(SECURITY_DISABLE_FLAG),
  .G0_IF_ENABLE(G0_IF_ENABLE),
  .NONSECURE_AFFINITY_ROUTING(NONSECURE_AFFINITY_ROUTING),
  .G1_SECURE_IF_ENABLE(G1_SECURE_IF_ENABLE),
  .G1_NONSECURE_IF_ENABLE(G1_NONSECURE_IF_ENABLE),
  .CORE_SLEEP_FLAG(CORE_SLEEP_FLAG),
  .CHILDREN_QUIESCED_FLAG(CHILDREN_QUIESCED_FLAG),
  .STATUS_UNDEFINED(STATUS_UNDEFINED), .ADDR(ADDR), .RDATA(RDATA));
module test_redist_sgi_ppi_misc_status;
  logic CLK, RSTN, WR, RD, NS, SD, RT, UND, IRQ;
  logic [15:0] ADDR;
  logic [31:0] WDATA, RDATA, ERR, NSAC, EV;
  logic [63:0] SGI;
  logic [6:0] CFG, LN;
  int n_mismatch = 0;
  int check_count = 0;
  // ns,sd,rt,g0,g1s,g1ns,act,wake then expected status word
  logic [39:0] rows [8] = '{40'h1E_8000_0007, 40'h9D_4000_0011,
    40'hAF_C000_0012, 40'h98_0000_0010, 40'h58_0000_0001,
    40'hCE_8000_0012, 40'h25_4000_0002, 40'hF0_0000_0011};
  core_model CORE (.clk(CLK), .cfg(CFG), .lines(LN));
  redist_sgi_ppi_misc_status DUT (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .ACCESS_NONSECURE(NS), .RDATA(RDATA),
    .CORE_ACTIVE(LN[1]), .WAKE_REQUEST(LN[0]), .CORE_SLEEP_FLAG(LN[6]),
    .CHILDREN_QUIESCED_FLAG(LN[5]), .SECURITY_DISABLE_FLAG(SD),
    .NONSECURE_AFFINITY_ROUTING(RT), .G0_IF_ENABLE(LN[4]),
    .G1_SECURE_IF_ENABLE(LN[3]), .G1_NONSECURE_IF_ENABLE(LN[2]),
    .ERROR_SET(ERR), .NONSECURE_ACCESS_CONTROL(NSAC),
    .INTERRUPT_ERROR_VALID(EV), .SGI_DEFAULT_SETTINGS(SGI),
    .STATUS_UNDEFINED(UND), .IRQ(IRQ));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
    @(posedge CLK) WR <= 1'b0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
    @(posedge CLK) RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Whole run needs under 200 cycles
  initial begin
    #20000 n_mismatch++;
    end_of_test;
  end
  initial begin
    {RSTN, WR, RD, NS, SD, RT, ADDR, WDATA, ERR, CFG} = '0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rc(16'h0E00, 32'h0);
    rc(16'hC008, 32'h0);
    $display("reset values done");
    foreach (rows[i]) begin
      @(posedge CLK) {NS, SD, RT, CFG} <=
        {rows[i][39:37], 2'b0, rows[i][36:32]};
      rc(16'hC000, rows[i][31:0]);
    end
    $display("status table done");
    rc(16'hC004, 32'h0);
    wr(16'hC000, 32'hFFFF_FFFF);
    rc(16'hC000, 32'h0000_0011);
    wr(16'h0E00, 32'h1234_5678);
    rc(16'h0E00, 32'h1234_5678);
    chk(NSAC, 32'h1234_5678);
    // Reserved nibble bits must stay clear in both words
    wr(16'hC010, 32'hFFFF_FFFF);
    wr(16'hC014, 32'hFFFF_FFFF);
    rc(16'hC010, 32'h7777_7777);
    rc(16'hC014, 32'h7777_7777);
    chk(SGI[31:0], 32'h7777_7777);
    chk(SGI[63:32], 32'h7777_7777);
    rc(16'hF000, redist_misc_pkg::CONFIG_ID_LOW_VAL);
    rc(16'hF004, redist_misc_pkg::CONFIG_ID_HIGH_VAL);
    @(posedge CLK) ERR <= 32'h0001_8001;
    @(posedge CLK) ERR <= 32'h0;
    rc(16'hC008, 32'h0001_8001);
    chk({31'h0, IRQ}, 32'h0);
    wr(16'hC024, 32'h1);
    #1 chk({31'h0, IRQ}, 32'h1);
    wr(16'hC008, 32'h0000_8000);
    rc(16'hC008, 32'h0001_0001);
    wr(16'hC020, 32'h1);
    #1 chk({31'h0, IRQ}, 32'h0);
    // Wake rose during the status table
    rc(16'hC020, 32'h0000_0002);
    // Clear and new error on one bit in one cycle: the set must win
    @(posedge CLK) {ADDR, WDATA, WR, ERR} <=
      {16'hC008, 32'h0000_0002, 1'b1, 32'h0000_0002};
    @(posedge CLK) {WR, ERR} <= '0;
    rc(16'hC008, 32'h0001_0003);
    chk(EV, 32'h0001_0003);
    @(posedge CLK) CFG <= 7'h40;
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, UND}, 32'h1);
    @(posedge CLK) CFG <= 7'h20;
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, UND}, 32'h1);
    @(posedge CLK) CFG <= 7'h00;
    repeat (2) @(posedge CLK);
    #1 chk({31'h0, UND}, 32'h0);
    $display("edge cases done");
    @(posedge CLK) RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    #1 chk(NSAC, 32'h0);
    chk(EV, 32'h0);
    chk(SGI[31:0], 32'h0);
    chk(SGI[63:32], 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    rc(16'hC024, 32'h0);
    $display("mid-run reset done");
    end_of_test;
  end
endmodule // test_redist_sgi_ppi_misc_status
`default_nettype wire
